// file: verilog/emmcr_pkg.sv
package emmcr_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h3a;
    localparam logic [7:0] ADDR_HOLD = 8'h3b;
    localparam logic [7:0] ADDR_BER_A = 8'h1e;
    localparam logic [7:0] ADDR_BER_B = 8'h1f;

    // ----------------------------------------------------------------
    // Field layouts and codes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_DDR = 3'h2;
    localparam logic [2:0] MODE_PRBS = 3'h5;
    localparam int MODE_MSB = 2;
    localparam int HOLD_BIT = 1;
    localparam int WIN_MSB = 7;
    localparam int WIN_LSB = 5;
    localparam int START_BIT = 3;
    localparam int SEL_MSB = 2;
    localparam int BEN_BIT = 5;
    localparam int STBY_BIT = 4;
    localparam int OM_OFFSET_BIT = 0;
    localparam int OM_HALF_BIT = 1;
    localparam int OM_RSVD_BIT = 2;
    localparam int CNT_W = 40;
    localparam int NUM_BYTES = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [5:0] WIN_BASE_EXP = 6'h12;
    localparam logic [5:0] WIN_STEP_EXP = 6'h03;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int LOS_ASSERT_NS = 450;
    localparam int LOS_DEASSERT_NS = 500;
    localparam logic [3:0] LOS_ASSERT_CYC =
        4'((LOS_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] LOS_DEASSERT_CYC =
        4'((LOS_DEASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Meter states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EMMCR_IDLE = 2'h0,
        EMMCR_RUN = 2'h1,
        EMMCR_DONE = 2'h3
    } emmcr_meter_e;

endpackage : emmcr_pkg

// file: verilog/emmcr_los_if.sv
`timescale 1ns/1ps
interface emmcr_los_if;
    logic sig_present;
    logic loss_flag;
    modport timer (input sig_present, output loss_flag);
    modport ctrl (output sig_present, input loss_flag);
endinterface : emmcr_los_if

// file: verilog/emmcr_los_timer.sv
`timescale 1ns/1ps
module emmcr_los_timer
    import emmcr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    emmcr_los_if.timer bus
);

    typedef struct packed {
        logic loss;
        logic [3:0] cnt;
    } emmcr_los_s;

    emmcr_los_s q;
    emmcr_los_s d;

    // ----------------------------------------------------------------
    // Flag filter
    // ----------------------------------------------------------------
    // Count while input and flag disagree; a short glitch restarts the count
    always_comb begin
        d = q;
        if (bus.sig_present == q.loss) begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == (q.loss ? LOS_DEASSERT_CYC : LOS_ASSERT_CYC) - 4'h1) begin
                d.loss = !q.loss;
                d.cnt = 4'h0;
            end
        end else begin
            d.cnt = 4'h0;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.loss_flag = q.loss;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_loss_assert_time: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!bus.loss_flag && !bus.sig_present) [*5] |=> bus.loss_flag)
        else $error("Loss flag not raised after input removal time");

    a_loss_clear_time: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (bus.loss_flag && bus.sig_present) [*5] |=> !bus.loss_flag)
        else $error("Loss flag not cleared after input return time");

endmodule : emmcr_los_timer

// file: verilog/emmcr_top.sv
// Function
// - Mode code 010 enables double data rate, 101 the pattern engine.
// - Holdover bit one set to one selects clock holdover; others written zero.
// - Window code bits 7:5 selects 2^18 up to 2^39 counted bits.
// - Writing one then zero to start bit launches a new measurement.
// - Bits 2:0 pick which byte of the 40-bit error count reads back.
// - Monitor enable bit five low disables the error meter.
// - Standby bit four high pauses measurement; low keeps it running.
// - Output mode routes normal or offset slicer, full or half clock.
// - Loss flag rises five clocks (500 ns) after input loss, clears 500 ns.
`timescale 1ns/1ps
module emmcr_top
    import emmcr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic bit_tick_i,
    input wire logic bit_err_i,
    input wire logic sig_present_i,
    output logic ddr_mode_o,
    output logic prbs_en_o,
    output logic holdover_o,
    output logic offset_slicer_path_o,
    output logic half_clock_o,
    output logic meas_done_o,
    output logic [7:0] result_byte_o,
    output logic signal_loss_flag_o
);

    // ----------------------------------------------------------------
    // Decoders
    // ----------------------------------------------------------------
    // Last bit index of the window for a given code
    function automatic logic [CNT_W-1:0] win_last(input logic [2:0] code);
        logic [5:0] sh;
        sh = WIN_BASE_EXP + 6'(WIN_STEP_EXP * code);
        return ({{(CNT_W-1){1'b0}}, 1'b1} << sh) - {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction : win_last

    // One byte of the count; byte five lies above the count and reads zero
    function automatic logic [7:0] byte_of(input logic [CNT_W-1:0] c,
                                           input logic [2:0] s);
        logic [8*NUM_BYTES-1:0] pad;
        pad = {8'h00, c};
        if (int'(s) < NUM_BYTES) begin
            return pad[8*int'(s) +: 8];
        end
        return 8'h00;
    endfunction : byte_of

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ddr;
        logic prbs;
        logic hold;
        logic [7:0] ctl_a;
        logic ben;
        logic stby;
        logic offs;
        logic half;
        emmcr_meter_e st;
        logic [CNT_W-1:0] bits;
        logic [CNT_W-1:0] errs;
        logic [7:0] res;
    } emmcr_top_s;

    emmcr_top_s q;
    emmcr_top_s d;
    logic start_pls;
    logic meter_tick;
    logic [2:0] byte_sel;

    // ----------------------------------------------------------------
    // Register writes and meter sequencing
    // ----------------------------------------------------------------
    // Writes to unmapped addresses are dropped without effect
    always_comb begin
        d = q;
        start_pls = 1'b0;
        if (wr_i) begin
            case (wr_addr_i)
                ADDR_MODE: begin
                    // Reserved codes leave both modes off
                    d.ddr = (wr_data_i[MODE_MSB:0] == MODE_DDR);
                    d.prbs = (wr_data_i[MODE_MSB:0] == MODE_PRBS);
                end
                ADDR_HOLD: begin
                    d.hold = wr_data_i[HOLD_BIT];
                end
                ADDR_BER_A: begin
                    // Start fires on the falling write so a held one does not restart
                    start_pls = q.ctl_a[START_BIT] && !wr_data_i[START_BIT];
                    d.ctl_a = wr_data_i;
                end
                ADDR_BER_B: begin
                    d.ben = wr_data_i[BEN_BIT];
                    d.stby = wr_data_i[STBY_BIT];
                    // Reserved output codes fall back to the normal slicer
                    d.offs = !wr_data_i[OM_RSVD_BIT] && wr_data_i[OM_OFFSET_BIT];
                    d.half = !wr_data_i[OM_RSVD_BIT] && wr_data_i[OM_HALF_BIT];
                end
                default: begin
                end
            endcase
        end
        meter_tick = (q.st == EMMCR_RUN) && !q.stby && bit_tick_i;
        case (q.st)
            EMMCR_IDLE: begin
            end
            EMMCR_RUN: begin
                if (meter_tick) begin
                    d.bits = q.bits + {{(CNT_W-1){1'b0}}, 1'b1};
                    d.errs = q.errs + {{(CNT_W-1){1'b0}}, bit_err_i};
                    if (q.bits == win_last(q.ctl_a[WIN_MSB:WIN_LSB])) begin
                        d.st = EMMCR_DONE;
                    end
                end
            end
            EMMCR_DONE: begin
                // Count frozen for readback
            end
            default: begin
                d.st = EMMCR_IDLE;
            end
        endcase
        if (start_pls && q.ben) begin
            d.st = EMMCR_RUN;
            d.bits = '0;
            d.errs = '0;
        end
        // Disabling stops the meter but keeps the last count readable
        if (!q.ben) begin
            d.st = EMMCR_IDLE;
        end
        d.res = byte_of(q.errs, q.ctl_a[SEL_MSB:0]);
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '{ddr: 1'b0, prbs: 1'b0, hold: 1'b0, ctl_a: REG_RESET,
                   ben: 1'b0, stby: 1'b0, offs: 1'b0, half: 1'b0,
                   st: EMMCR_IDLE, bits: '0, errs: '0, res: REG_RESET};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Loss of signal timer
    // ----------------------------------------------------------------
    emmcr_los_if los_bus ();

    assign los_bus.sig_present = sig_present_i;

    emmcr_los_timer u_los (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .bus(los_bus.timer)
    );

    // Outputs
    assign signal_loss_flag_o = los_bus.loss_flag;
    assign ddr_mode_o = q.ddr;
    assign prbs_en_o = q.prbs;
    assign holdover_o = q.hold;
    assign offset_slicer_path_o = q.offs;
    assign half_clock_o = q.half;
    assign meas_done_o = (q.st == EMMCR_DONE);
    assign result_byte_o = q.res;
    assign byte_sel = q.ctl_a[SEL_MSB:0];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_mode_ddr_decode: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_i && wr_addr_i == ADDR_MODE && wr_data_i[MODE_MSB:0] == MODE_DDR
        |=> ddr_mode_o && !prbs_en_o)
        else $error("Double data rate code did not select DDR alone");

    a_mode_prbs_decode: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_i && wr_addr_i == ADDR_MODE && wr_data_i[MODE_MSB:0] == MODE_PRBS
        |=> prbs_en_o && !ddr_mode_o)
        else $error("Pattern code did not select the pattern engine alone");

    a_holdover_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_i && wr_addr_i == ADDR_HOLD |=> holdover_o == $past(wr_data_i[HOLD_BIT]))
        else $error("Holdover output does not follow written bit");

    a_window_end: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        meter_tick && q.ben && !start_pls && q.bits == win_last(q.ctl_a[WIN_MSB:WIN_LSB])
        |=> meas_done_o)
        else $error("Measurement did not end at window length");

    a_start_run: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        start_pls && q.ben |=> q.st == EMMCR_RUN && q.errs == '0 && q.bits == '0)
        else $error("Start pulse did not launch a cleared measurement");

    // Checked by shifting the count, not through the readback decoder itself
    a_byte_select: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        int'(byte_sel) < CNT_W / 8
        |=> result_byte_o == 8'($past(q.errs) >> {$past(byte_sel), 3'h0}))
        else $error("Readback byte does not match selected count byte");

    a_byte_above: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        int'(byte_sel) >= CNT_W / 8 |=> result_byte_o == 8'h00)
        else $error("Byte above the count did not read zero");

    a_disable_idle: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !q.ben |=> q.st == EMMCR_IDLE)
        else $error("Meter running while disabled");

    a_standby_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        q.st == EMMCR_RUN && q.stby && !start_pls |=> $stable(q.bits) && $stable(q.errs))
        else $error("Counts moved during standby");

    a_route_mode: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_i && wr_addr_i == ADDR_BER_B && wr_data_i[OM_RSVD_BIT:0] == 3'h3
        |=> offset_slicer_path_o && half_clock_o)
        else $error("Offset half-rate route not selected");

    a_hold_count: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        meas_done_o && !start_pls |=> $stable(q.errs))
        else $error("Final count changed before next start");

endmodule : emmcr_top

// file: testbench/emmcr_host_model.sv
`timescale 1ns/1ps
// Host controller that makes the register writes on the management side
module emmcr_host_model
    import emmcr_pkg::*;
(
    input wire logic sys_clk_i,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [7:0] data_o
);
    // ----------------------------------------------------------------
    // Write cycles
    // ----------------------------------------------------------------
    initial begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        data_o = 8'h00;
    end

    // One write; strobe stands for one sampling edge, then data is scrambled
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        data_o = d;
        @(posedge sys_clk_i);
        #1;
        wr_o = 1'b0;
        data_o = ~data_o;
    endtask : put

    // Start pulse: start bit written high, then low
    task automatic start(input logic [2:0] win, input logic [2:0] sel);
        put(ADDR_BER_A, {win, 1'b0, 1'b1, sel});
        put(ADDR_BER_A, {win, 1'b0, 1'b0, sel});
    endtask : start

    // Holdover register: every bit but bit one stays zero
    task automatic hold(input logic on);
        put(ADDR_HOLD, {6'h00, on, 1'b0});
    endtask : hold

    // Mode register: only the two defined codes are sent
    task automatic mode(input logic prbs);
        put(ADDR_MODE, {5'h00, prbs ? MODE_PRBS : MODE_DDR});
    endtask : mode
endmodule : emmcr_host_model

// file: testbench/emmcr_tb_top.sv
`timescale 1ns/1ps
module emmcr_tb_top
    import emmcr_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, tick = 1'b0, err = 1'b1, sig = 1'b1;
    logic wr, ddr, prbs, hold, off, half, done, loss;
    logic [7:0] addr, data, res;
    int fails = 0, cmp_count = 0;

    // ----------------------------------------------------------------
    // Clock and instances
    // ----------------------------------------------------------------
    always #50 clk = ~clk;

    emmcr_host_model u_emmcr_host_model (.sys_clk_i(clk), .wr_o(wr), .addr_o(addr),
        .data_o(data));

    emmcr_top u_emmcr_top (.sys_clk_i(clk), .rstn_i(rstn), .wr_i(wr), .wr_addr_i(addr),
        .wr_data_i(data), .bit_tick_i(tick), .bit_err_i(err), .sig_present_i(sig),
        .ddr_mode_o(ddr), .prbs_en_o(prbs), .holdover_o(hold), .offset_slicer_path_o(off),
        .half_clock_o(half), .meas_done_o(done), .result_byte_o(res),
        .signal_loss_flag_o(loss));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // Error line idles high so a meter that ignores the tick qualifier shows it
    // An idle edge first, so back-to-back calls never flip the strobe twice at once
    task automatic ticks(input int n, input logic e);
        @(posedge clk);
        #1;
        tick = 1'b1;
        err = e;
        repeat (n) @(posedge clk);
        #1;
        tick = 1'b0;
        err = 1'b1;
    endtask : ticks

    // Result byte is registered, so it is read one edge after the select lands
    task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
        u_emmcr_host_model.put(ADDR_BER_A, {5'h00, sel});
        @(posedge clk);
        #1;
        chk(res, exp);
    endtask : rd

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_mode();
        u_emmcr_host_model.mode(1'b0);
        chk({6'h00, ddr, prbs}, 8'h02);
        u_emmcr_host_model.mode(1'b1);
        chk({6'h00, ddr, prbs}, 8'h01);
        u_emmcr_host_model.hold(1'b1);
        u_emmcr_host_model.put(8'h3c, 8'hff);
        chk({5'h00, ddr, prbs, hold}, 8'h03);
        u_emmcr_host_model.hold(1'b0);
        chk({7'h00, hold}, 8'h00);
        u_emmcr_host_model.mode(1'b0);
        chk({6'h00, ddr, prbs}, 8'h02);
    endtask : t_mode

    // Codes with bit two set are reserved and fall back to the normal path
    task automatic t_outmode();
        for (int c = 0; c < 5; c++) begin
            u_emmcr_host_model.put(ADDR_BER_B, 8'(c));
            chk({6'h00, off, half}, c < 4 ? 8'((c & 1) * 2 + (c >> 1)) : 8'h00);
        end
    endtask : t_outmode

    task automatic t_meter();
        logic [47:0] cnt;
        cnt = 48'd300;
        u_emmcr_host_model.put(ADDR_BER_B, 8'h20);
        u_emmcr_host_model.start(3'h0, 3'h0);
        ticks(300, 1'b1);
        ticks(50, 1'b0);
        chk({7'h00, done}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd(3'(i), cnt[8 * i +: 8]);
        end
        u_emmcr_host_model.put(ADDR_BER_B, 8'h30);
        ticks(20, 1'b1);
        rd(3'h0, 8'h2c);
        u_emmcr_host_model.put(ADDR_BER_B, 8'h20);
        ticks(10, 1'b1);
        rd(3'h0, 8'h36);
        u_emmcr_host_model.put(ADDR_BER_B, 8'h00);
        ticks(10, 1'b1);
        u_emmcr_host_model.start(3'h7, 3'h0);
        ticks(5, 1'b1);
        rd(3'h0, 8'h36);
        u_emmcr_host_model.put(ADDR_BER_B, 8'h20);
        u_emmcr_host_model.put(ADDR_BER_A, 8'h08);
        rd(3'h0, 8'h00);
        ticks(3, 1'b1);
        rd(3'h0, 8'h03);
        chk({7'h00, done}, 8'h00);
    endtask : t_meter

    // Flag must move on the fifth sample of the new level, not the fourth
    task automatic los_step(input logic present);
        sig = present;
        repeat (4) @(posedge clk);
        #1;
        chk({7'h00, loss}, {7'h00, present});
        @(posedge clk);
        #1;
        chk({7'h00, loss}, {7'h00, ~present});
    endtask : los_step

    task automatic t_los();
        sig = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        sig = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, loss}, 8'h00);
        los_step(1'b0);
        los_step(1'b1);
    endtask : t_los

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        chk({ddr, prbs, hold, off, half, done, loss, 1'b0}, 8'h00);
        chk(res, 8'h00);
        t_mode();
        t_outmode();
        t_meter();
        t_los();
        wrap_up();
    end

    // The whole run needs well under a thousand cycles
    initial begin
        #300000;
        fails++;
        wrap_up();
    end
endmodule : emmcr_tb_top
